// [core/op_cap_pkg.sv]
// Package for the logical operation capability register bank.
package op_cap_pkg;

  // Register offsets within the configuration space (byte addresses).
  localparam logic [23:0] OFF_ISSUE_CAP = 24'h000018;
  localparam logic [23:0] OFF_ACCEPT_CAP = 24'h00001C;
  localparam logic [23:0] OFF_LL_CTRL = 24'h00004C;
  localparam logic [23:0] OFF_BASE_UPPER = 24'h000058;
  localparam logic [23:0] OFF_BASE_LOWER = 24'h00005C;

  // Capability bit positions, numbered from the LSB (bit 0 = LSB).
  // The documented numbering counts from the MSB, so doc bit n is 31-n.
  localparam int BIT_READ = 31 - 16;
  localparam int BIT_WRITE = 31 - 17;
  localparam int BIT_STREAM_WR = 31 - 18;
  localparam int BIT_WR_RESP = 31 - 19;
  localparam int BIT_ATOMIC_HI = 31 - 22;
  localparam int BIT_ATOMIC_LO = 31 - 28;
  localparam int BIT_PORT_WRITE = 31 - 29;

  // Bits that may be nonzero in a capability register: doc bits 14-19,
  // 22-31. Doc bits 0-13 and 20-21 are reserved and read as zero.
  localparam logic [31:0] CAP_VALID_MASK = 32'h0003F3FF;
  // Implementation-defined flags: doc bits 14-15 and 30-31.
  localparam logic [31:0] CAP_IMPL_MASK = 32'h00030003;
  // Only the port-write flag is meaningful in a switch-only element.
  localparam logic [31:0] CAP_SWITCH_MASK = 32'h00000004;

  // Address-width control: doc bits 29-31 are LSB bits 2:0.
  localparam logic [2:0] AW_66 = 3'h4;
  localparam logic [2:0] AW_50 = 3'h2;
  localparam logic [2:0] AW_34 = 3'h1;
  localparam logic [2:0] AW_RESET = AW_34;

  // Writable bits of the base registers (doc bit 0 is the LSB-side bit 31).
  localparam logic [31:0] BASE_UPPER_MASK = 32'h7FFFFFFF;
  localparam logic [31:0] BASE_LOWER_MASK = 32'hFFFFFFFF;
  localparam logic [31:0] BASE_RESET = 32'h00000000;

  // Size of the mapped configuration window in double-words (offset bits).
  localparam int CFG_SPACE_DW_BITS = 21;

  typedef enum logic [1:0] {
    ACC_IDLE = 2'b00,
    ACC_READ = 2'b01,
    ACC_WRITE = 2'b10
  } acc_kind_t;

  // One register request: maintenance or mapped local access.
  typedef struct packed {
    acc_kind_t kind;
    logic [23:0] offset;
    logic [31:0] wdata;
  } cfg_req_t;

  // Local bus request in physical address space (up to 66 bits).
  typedef struct packed {
    acc_kind_t kind;
    logic [65:0] addr;
    logic [31:0] wdata;
  } local_req_t;

  typedef struct packed {
    logic valid;
    logic error;
    logic [31:0] rdata;
  } cfg_rsp_t;

endpackage

// [core/op_cap_regs.sv]
// Capability, logical control and config base registers of an element.
`timescale 1ns/1ns
module op_cap_regs #(
  parameter logic [31:0] ISSUE_CAPS = 32'h0003F3C4,
  parameter logic [31:0] ACCEPT_CAPS = 32'h0003F3C4,
  parameter logic [31:0] IMPL_BITS = 32'h00000000,
  parameter bit SWITCH_ONLY = 1'b0,
  parameter bit HAS_END_POINT = 1'b1
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // Incoming maintenance requests
  input wire op_cap_pkg::cfg_req_t i_maint_req,
  output op_cap_pkg::cfg_rsp_t o_maint_rsp,
  // Ordinary local reads and writes
  input wire op_cap_pkg::local_req_t i_local_req,
  output op_cap_pkg::cfg_rsp_t o_local_rsp,
  // Current address width selection and base-valid flag for the packet logic
  output logic [2:0] o_addr_width,
  output logic o_base_valid
);
  import op_cap_pkg::*;

  logic [2:0] aw_q;
  logic [31:0] base_up_q;
  logic [31:0] base_lo_q;
  cfg_rsp_t maint_rsp_q;
  cfg_rsp_t local_rsp_q;
  logic base_valid_q;
  logic [63:0] base_dw;
  logic [63:0] local_dw;
  logic local_hit;
  cfg_req_t local_cfg;
  logic [31:0] issue_val;
  logic [31:0] accept_val;
  logic [32:0] maint_rd;
  logic [32:0] local_rd;

  // Builds a capability word field by field. Implementation bits may
  // come from either parameter, but never leak into reserved positions.
  function automatic logic [31:0] cap_fields(input logic [31:0] caps,
                                             input logic [31:0] impl);
    logic [31:0] f;
    f = (caps | impl) & CAP_IMPL_MASK;
    f[BIT_READ] = caps[BIT_READ];
    f[BIT_WRITE] = caps[BIT_WRITE];
    f[BIT_STREAM_WR] = caps[BIT_STREAM_WR];
    f[BIT_WR_RESP] = caps[BIT_WR_RESP];
    f[BIT_ATOMIC_HI:BIT_ATOMIC_LO] =
      caps[BIT_ATOMIC_HI:BIT_ATOMIC_LO];
    f[BIT_PORT_WRITE] = caps[BIT_PORT_WRITE];
    cap_fields = f & CAP_VALID_MASK;
  endfunction

  // Element reports its origination set; the maintenance origination
  // needed to reach other elements is implied and has no flag.
  // A switch-only element keeps just the port-write flag.
  assign issue_val = SWITCH_ONLY ?
    (ISSUE_CAPS & CAP_SWITCH_MASK) :
    cap_fields(ISSUE_CAPS, IMPL_BITS);
  // Accept flags are defined only where an end point exists.
  assign accept_val = HAS_END_POINT ?
    cap_fields(ACCEPT_CAPS, IMPL_BITS) :
    32'h00000000;

  // Field masks for each width: unused bits stay zero so they read zero.
  function automatic logic [31:0] upper_mask(input logic [2:0] aw);
    unique case (aw)
      AW_66: upper_mask = BASE_UPPER_MASK;
      AW_50: upper_mask = 32'h00007FFF;
      default: upper_mask = 32'h00000000;
    endcase
  endfunction

  function automatic logic [31:0] lower_mask(input logic [2:0] aw);
    unique case (aw)
      AW_66, AW_50: lower_mask = BASE_LOWER_MASK;
      default: lower_mask = 32'h7FFFFFFF;
    endcase
  endfunction

  // Register read decode shared by both access paths.
  function automatic logic [32:0] rd_reg(input logic [23:0] off,
                                         input logic [2:0] aw,
                                         input logic [31:0] up,
                                         input logic [31:0] lo,
                                         input logic [31:0] iss,
                                         input logic [31:0] acc);
    unique case (off)
      OFF_ISSUE_CAP: rd_reg = {1'b0, iss};
      OFF_ACCEPT_CAP: rd_reg = {1'b0, acc};
      OFF_LL_CTRL: rd_reg = {1'b0, 29'h0, aw};
      OFF_BASE_UPPER: rd_reg = {1'b0, up & upper_mask(aw)};
      OFF_BASE_LOWER: rd_reg = {1'b0, lo & lower_mask(aw)};
      default: rd_reg = {1'b1, 32'h00000000};
    endcase
  endfunction

  function automatic logic legal_aw(input logic [2:0] code);
    legal_aw = (code == AW_66) || (code == AW_50) || (code == AW_34);
  endfunction

  function automatic logic [30:0] up_part(input logic [2:0] aw,
                                          input logic [31:0] up);
    logic [31:0] m;
    m = upper_mask(aw);
    up_part = up[30:0] & m[30:0];
  endfunction

  // The base is a double-word offset concatenated from both registers.
  assign base_dw = {1'b0, up_part(aw_q, base_up_q), base_lo_q};

  // Read decode for each path, held in a net so its flag can be selected.
  assign maint_rd = rd_reg(i_maint_req.offset, aw_q, base_up_q, base_lo_q,
                           issue_val, accept_val);
  assign local_rd = rd_reg(local_cfg.offset, aw_q, base_up_q, base_lo_q,
                           issue_val, accept_val);

  // Physical double-word index of the local access, limited by width.
  always_comb begin
    local_dw = 64'h0;
    unique case (aw_q)
      AW_66: local_dw = {1'b0, i_local_req.addr[65:3]};
      AW_50: local_dw = {17'h0, i_local_req.addr[49:3]};
      default: local_dw = {33'h0, i_local_req.addr[33:3]};
    endcase
  end

  // Mapped window: accesses inside it are register accesses.
  assign local_hit = base_valid_q && (i_local_req.kind != ACC_IDLE) &&
    ((local_dw >> CFG_SPACE_DW_BITS) ==
     ((base_dw & (base_mask_for(aw_q))) >> CFG_SPACE_DW_BITS));

  function automatic logic [63:0] base_mask_for(input logic [2:0] aw);
    unique case (aw)
      AW_66: base_mask_for = 64'h7FFFFFFFFFFFFFFF;
      AW_50: base_mask_for = 64'h00007FFFFFFFFFFF;
      default: base_mask_for = 64'h000000007FFFFFFF;
    endcase
  endfunction

  always_comb begin
    local_cfg.kind = local_hit ? i_local_req.kind : ACC_IDLE;
    local_cfg.offset = {i_local_req.addr[20:2], 2'b00} & 24'hFFFFFC;
    local_cfg.wdata = i_local_req.wdata;
  end

  // Control register: illegal width codes are ignored, keeping the mode.
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      aw_q <= AW_RESET;
    end else if (i_maint_req.kind == ACC_WRITE &&
                 i_maint_req.offset == OFF_LL_CTRL &&
                 legal_aw(i_maint_req.wdata[2:0])) begin
      aw_q <= i_maint_req.wdata[2:0];
    end else if (local_cfg.kind == ACC_WRITE &&
                 local_cfg.offset == OFF_LL_CTRL &&
                 legal_aw(local_cfg.wdata[2:0])) begin
      aw_q <= local_cfg.wdata[2:0];
    end
  end

  // Base registers. Maintenance wins over a simultaneous local write.
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      base_up_q <= BASE_RESET;
      base_lo_q <= BASE_RESET;
    end else if (i_maint_req.kind == ACC_WRITE) begin
      if (i_maint_req.offset == OFF_BASE_UPPER)
        base_up_q <= i_maint_req.wdata & BASE_UPPER_MASK;
      if (i_maint_req.offset == OFF_BASE_LOWER)
        base_lo_q <= i_maint_req.wdata;
    end else if (local_cfg.kind == ACC_WRITE) begin
      if (local_cfg.offset == OFF_BASE_UPPER)
        base_up_q <= local_cfg.wdata & BASE_UPPER_MASK;
      if (local_cfg.offset == OFF_BASE_LOWER)
        base_lo_q <= local_cfg.wdata;
    end
  end

  // Mapping becomes live once software has written either base word.
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      base_valid_q <= 1'b0;
    end else if (i_maint_req.kind == ACC_WRITE &&
                 (i_maint_req.offset == OFF_BASE_UPPER ||
                  i_maint_req.offset == OFF_BASE_LOWER)) begin
      base_valid_q <= 1'b1;
    end
  end

  // Maintenance answers, one cycle after the request. Writes to the
  // capability offsets are acknowledged but change nothing.
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      maint_rsp_q <= '0;
    end else begin
      maint_rsp_q.valid <= (i_maint_req.kind != ACC_IDLE);
      maint_rsp_q.error <= (i_maint_req.kind != ACC_IDLE) && maint_rd[32];
      maint_rsp_q.rdata <= (i_maint_req.kind == ACC_READ) ?
        maint_rd[31:0] : 32'h00000000;
    end
  end

  // Local answers use the same decode, so organisation is identical.
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      local_rsp_q <= '0;
    end else begin
      local_rsp_q.valid <= (local_cfg.kind != ACC_IDLE);
      local_rsp_q.error <= (local_cfg.kind != ACC_IDLE) && local_rd[32];
      local_rsp_q.rdata <= (local_cfg.kind == ACC_READ) ?
        local_rd[31:0] : 32'h00000000;
    end
  end

  // Switch forwarding does not consult these flags; nothing here gates it.
  assign o_maint_rsp = maint_rsp_q;
  assign o_local_rsp = local_rsp_q;
  assign o_addr_width = aw_q;
  assign o_base_valid = base_valid_q;

endmodule

// [tb/op_cap_regs_monitor.sv]
// Port checker for the capability register bank, with its bind.
`timescale 1ns/1ns
module op_cap_regs_monitor (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // Watched ports
  input wire op_cap_pkg::cfg_req_t i_maint_req,
  input wire op_cap_pkg::cfg_rsp_t o_maint_rsp,
  input wire op_cap_pkg::local_req_t i_local_req,
  input wire op_cap_pkg::cfg_rsp_t o_local_rsp,
  input wire logic [2:0] o_addr_width,
  input wire logic o_base_valid
);
  import op_cap_pkg::*;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  wire logic mrd = i_maint_req.kind == ACC_READ;
  wire logic mwr = i_maint_req.kind == ACC_WRITE;
  wire logic [23:0] off = i_maint_req.offset;
  wire logic [2:0] code = i_maint_req.wdata[2:0];
  wire logic legal = code inside {AW_66, AW_50, AW_34};
  property p_answer;
    i_maint_req.kind != ACC_IDLE |=> o_maint_rsp.valid; endproperty
  a_answer: assert property (p_answer) else $error("no answer");
  property p_aw_reset;
    $rose(i_rst_n) |-> o_addr_width == AW_34; endproperty
  a_aw_reset: assert property (p_aw_reset) else $error("width");
  property p_aw_set;
    mwr && off == OFF_LL_CTRL && legal |=> o_addr_width == $past(code);
  endproperty
  a_aw_set: assert property (p_aw_set) else $error("width set");
  property p_aw_keep;
    mwr && off == OFF_LL_CTRL && !legal && i_local_req.kind == ACC_IDLE
      |=> $stable(o_addr_width); endproperty
  a_aw_keep: assert property (p_aw_keep) else $error("width kept");
  property p_cap_rsvd;
    mrd && (off == OFF_ISSUE_CAP || off == OFF_ACCEPT_CAP)
      |=> (o_maint_rsp.rdata & ~CAP_VALID_MASK) == 32'h0; endproperty
  a_cap_rsvd: assert property (p_cap_rsvd) else $error("rsvd");
  property p_ctrl_rd;
    mrd && off == OFF_LL_CTRL |=> o_maint_rsp.rdata == {29'h0, o_addr_width};
  endproperty
  a_ctrl_rd: assert property (p_ctrl_rd) else $error("ctrl rd");
  property p_base_vld;
    mwr && (off == OFF_BASE_UPPER || off == OFF_BASE_LOWER) |=> o_base_valid;
  endproperty
  a_base_vld: assert property (p_base_vld) else $error("base");
  property p_loc_miss;
    !o_base_valid && i_local_req.kind != ACC_IDLE |=> !o_local_rsp.valid;
  endproperty
  a_loc_miss: assert property (p_loc_miss) else $error("miss");
endmodule
bind op_cap_regs op_cap_regs_monitor i_op_cap_regs_monitor (
  .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_maint_req(i_maint_req),
  .o_maint_rsp(o_maint_rsp), .i_local_req(i_local_req),
  .o_local_rsp(o_local_rsp), .o_addr_width(o_addr_width),
  .o_base_valid(o_base_valid));

// [tb/remote_pe_model.sv]
// Remote element that issues maintenance requests to the bank.
`timescale 1ns/1ns
module remote_pe_model (
  // Clock
  input wire logic i_ref_clk,
  // Request and its answer
  output op_cap_pkg::cfg_req_t o_req,
  input wire op_cap_pkg::cfg_rsp_t i_rsp
);
  import op_cap_pkg::*;
  initial o_req = '0;
  // Released data is inverted so a stale value is never mistaken for live.
  task automatic maint(input acc_kind_t k, input logic [23:0] a,
                       input logic [31:0] wd, output cfg_rsp_t rsp);
    @(negedge i_ref_clk);
    o_req = '{k, a, wd};
    @(negedge i_ref_clk);
    rsp = i_rsp;
    o_req = '{ACC_IDLE, ~a, ~wd};
  endtask
endmodule

// [tb/tb_top.sv]
// Self-checking bench for the capability register bank.
`timescale 1ns/1ns
module tb_top;
  import op_cap_pkg::*;
  logic i_ref_clk, i_rst_n, o_base_valid;
  logic [2:0] o_addr_width;
  cfg_req_t i_maint_req;
  cfg_rsp_t o_maint_rsp, o_local_rsp, r, sw_rsp;
  local_req_t i_local_req;
  int n_mismatch = 0;
  int n_compared = 0;
  op_cap_regs #(.ISSUE_CAPS(32'h0000FFFC), .ACCEPT_CAPS(32'h00008004))
    i_op_cap_regs (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
    .i_maint_req(i_maint_req), .o_maint_rsp(o_maint_rsp),
    .i_local_req(i_local_req), .o_local_rsp(o_local_rsp),
    .o_addr_width(o_addr_width), .o_base_valid(o_base_valid));
  // A switch-only element without end point sees the same requests.
  op_cap_regs #(.ISSUE_CAPS(32'h0000FFFC), .ACCEPT_CAPS(32'h00008004),
    .SWITCH_ONLY(1'b1), .HAS_END_POINT(1'b0))
    i_op_cap_regs_sw (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
    .i_maint_req(i_maint_req), .o_maint_rsp(sw_rsp),
    .i_local_req(i_local_req), .o_local_rsp(),
    .o_addr_width(), .o_base_valid());
  remote_pe_model i_remote_pe_model (.i_ref_clk(i_ref_clk),
    .o_req(i_maint_req), .i_rsp(o_maint_rsp));
  task automatic check(input logic [33:0] got, input logic [33:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [23:0] a, input logic [31:0] exp);
    i_remote_pe_model.maint(ACC_READ, a, 32'h0, r);
    check({r.valid, r.error, r.rdata}, {2'b10, exp});
  endtask
  task automatic wr(input logic [23:0] a, input logic [31:0] wd);
    i_remote_pe_model.maint(ACC_WRITE, a, wd, r);
    check({r.valid, r.error, 32'h0}, {2'b10, 32'h0});
  endtask
  task automatic loc(input acc_kind_t k, input logic [65:0] a,
                     input logic [31:0] wd);
    @(negedge i_ref_clk);
    i_local_req = '{k, a, wd};
    @(negedge i_ref_clk);
    r = o_local_rsp;
    i_local_req = '{ACC_IDLE, ~a, ~wd};
  endtask
  task automatic t_reset();
    rd(OFF_LL_CTRL, 32'h1);
    rd(OFF_BASE_LOWER, 32'h0);
    loc(ACC_READ, 66'h100004C, 32'h0);
    check({33'h0, r.valid | o_base_valid}, 34'h0);
    i_remote_pe_model.maint(ACC_READ, 24'h000100, 32'h0, r);
    check({r.valid, r.error, r.rdata}, {2'b11, 32'h0});
  endtask
  // The issue value parks the two reserved bits high; they must read 0.
  task automatic t_caps();
    rd(OFF_ISSUE_CAP, 32'h0000F3FC);
    rd(OFF_ACCEPT_CAP, 32'h00008004);
    wr(OFF_ISSUE_CAP, 32'hFFFFFFFF);
    rd(OFF_ISSUE_CAP, 32'h0000F3FC);
  endtask
  // The switch instance answers in the same cycle as the main one.
  task automatic t_switch();
    rd(OFF_ISSUE_CAP, 32'h0000F3FC);
    check({sw_rsp.valid, sw_rsp.error, sw_rsp.rdata}, 34'h200000004);
    rd(OFF_ACCEPT_CAP, 32'h00008004);
    check({sw_rsp.valid, sw_rsp.error, sw_rsp.rdata}, 34'h200000000);
  endtask
  task automatic t_width();
    logic [2:0] c [6] = '{3'h4, 3'h2, 3'h3, 3'h1, 3'h0, 3'h7};
    logic [2:0] e [6] = '{3'h4, 3'h2, 3'h2, 3'h1, 3'h1, 3'h1};
    for (int i = 0; i < 6; i++) begin
      wr(OFF_LL_CTRL, {29'h0, c[i]});
      check({31'h0, o_addr_width}, {31'h0, e[i]});
      rd(OFF_LL_CTRL, {29'h0, e[i]});
    end
  endtask
  task automatic t_base();
    wr(OFF_LL_CTRL, 32'h4);
    wr(OFF_BASE_UPPER, 32'hFFFFFFFF);
    rd(OFF_BASE_UPPER, 32'h7FFFFFFF);
    wr(OFF_LL_CTRL, 32'h2);
    rd(OFF_BASE_UPPER, 32'h00007FFF);
    wr(OFF_BASE_LOWER, 32'hFFFFFFFF);
    rd(OFF_BASE_LOWER, 32'hFFFFFFFF);
    wr(OFF_LL_CTRL, 32'h1);
    rd(OFF_BASE_UPPER, 32'h0);
    rd(OFF_BASE_LOWER, 32'h7FFFFFFF);
    wr(OFF_BASE_UPPER, 32'h0);
    wr(OFF_BASE_LOWER, 32'h00200000);
    loc(ACC_READ, 66'h200004C, 32'h0);
    check({33'h0, r.valid}, 34'h0);
    loc(ACC_READ, 66'h100004C, 32'h0);
    check({r.valid, r.error, r.rdata}, {2'b10, 32'h1});
    loc(ACC_WRITE, 66'h100004C, 32'h2);
    check({31'h0, o_addr_width}, 34'h2);
    wr(OFF_LL_CTRL, 32'h1);
  endtask
  task automatic stop_test();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    i_ref_clk = 1'b0;
    forever #25 i_ref_clk = ~i_ref_clk;
  end
  initial begin
    i_rst_n = 1'b0;
    i_local_req = '0;
    repeat (6) @(posedge i_ref_clk);
    @(negedge i_ref_clk);
    i_rst_n = 1'b1;
    t_reset();
    t_caps();
    t_switch();
    t_width();
    t_base();
    stop_test();
  end
  // About forty two-cycle requests; this limit leaves ample slack.
  initial begin
    #100000;
    n_mismatch++;
    stop_test();
  end
endmodule
